// ### logic/strap_cfg_pkg.sv
// Constants for the strap-driven mode and advertisement configuration block.
// Assumes a single 40 MHz core clock; no register bus, plain ports only.
package strap_cfg_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_PS      = 25000;
  localparam int ISO_CLEAR_MAX_US   = 100;
  localparam int ISO_RESET_MAX_US   = 500;
  // Longest times round down to whole cycles
  localparam int ISO_CLEAR_CYC      = (ISO_CLEAR_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int ISO_RESET_CYC      = (ISO_RESET_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int ISO_CNT_W          = 16;

  // ****************************************
  // Basic control register layout
  // ****************************************
  localparam logic [4:0] CTRL_OFFSET     = 5'h00;
  localparam int         CTRL_RESET_BIT  = 15;
  localparam int         CTRL_SPEED_BIT  = 13;
  localparam int         CTRL_AUTONEG_STRAP_ENABLE_BIT  = 12;
  localparam int         CTRL_ISO_BIT    = 10;
  localparam int         CTRL_RESTART_BIT = 9;
  localparam int         CTRL_DUPLEX_BIT = 8;

  // ****************************************
  // Advertisement register layout
  // ****************************************
  localparam int         ADV_LSB         = 5;
  localparam int         ADV_MSB         = 8;
  localparam logic [4:0] ADV_SELECTOR    = 5'h01;
  // Ability bits within [8:5]: 100FD,100HD,10FD,10HD
  localparam logic [3:0] ADV_10_BOTH     = 4'h3;
  localparam logic [3:0] ADV_100_BOTH    = 4'hC;
  localparam logic [3:0] ADV_HALF_ONLY   = 4'h5;
  localparam logic [3:0] ADV_ALL         = 4'hF;
  localparam logic [3:0] ADV_NONE        = 4'h0;

  typedef enum logic [1:0] {
    MODE_10_HALF,
    MODE_10_FULL,
    MODE_100_HALF,
    MODE_100_FULL
  } link_mode_t;

endpackage

// ### logic/ability_resolver.sv
// Picks the best common mode from local and partner ability sets.
// Assumes ability vectors ordered 100FD,100HD,10FD,10HD from msb down.
`timescale 1ns/1ps
`default_nettype none

module ability_resolver
(
  input  wire logic [3:0]                    local_ability,
  input  wire logic [3:0]                    partner_ability,
  output logic                               common_found,
  output strap_cfg_pkg::link_mode_t          best_mode
);

  logic [3:0] common;

  // ****************************************
  // Priority resolution
  // ****************************************
  always_comb
  begin
    common       = local_ability & partner_ability;
    common_found = |common;
    if (common[3])
      best_mode = strap_cfg_pkg::MODE_100_FULL;
    else if (common[2])
      best_mode = strap_cfg_pkg::MODE_100_HALF;
    else if (common[1])
      best_mode = strap_cfg_pkg::MODE_10_FULL;
    else
      best_mode = strap_cfg_pkg::MODE_10_HALF;
  end

endmodule

`default_nettype wire

// ### logic/autoneg_mode_strap_config.sv
// Strap capture, forced-mode and advertisement setup, control writes, isolate exit.
// Assumes straps and management strobes synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module autoneg_mode_strap_config
#(
  parameter int ISO_RESET_CYC = strap_cfg_pkg::ISO_RESET_CYC,
  parameter int ISO_CLEAR_CYC = strap_cfg_pkg::ISO_CLEAR_CYC
)
(
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  input  wire logic                          autoneg_strap_enable,
  input  wire logic                          ability_strap_hi,
  input  wire logic                          ability_strap_lo,
  input  wire logic                          ctrl_wr,
  input  wire logic [15:0]                   ctrl_wdata,
  input  wire logic                          adv_wr,
  input  wire logic [3:0]                    adv_wdata,
  input  wire logic [3:0]                    partner_ability,
  input  wire logic                          partner_valid,
  output logic [15:0]                        basic_control_reg,
  output logic [15:0]                        advertised_ability_reg,
  output logic                               autoneg_active,
  output logic                               autoneg_complete,
  output logic                               restart_pulse,
  output logic                               isolate,
  output strap_cfg_pkg::link_mode_t          link_mode
);

  logic        captured_r;
  logic [2:0]  strap_r;
  logic        autoneg_strap_enable_r;
  logic        speed_r;
  logic        duplex_r;
  logic        iso_bit_r;
  logic        soft_reset_r;
  logic [3:0]  adv_r;
  logic        complete_r;
  logic        restart_r;
  localparam int ISO_CNT_W_L = strap_cfg_pkg::ISO_CNT_W;

  logic        isolate_r;
  logic [ISO_CNT_W_L-1:0] iso_cnt_r;
  logic        common_found;
  logic [3:0]  strap_adv;
  strap_cfg_pkg::link_mode_t neg_mode;
  strap_cfg_pkg::link_mode_t mode_r;

  // Software reset only acts on enabled edges
  wire sw_reset = clk_en && ctrl_wr && ctrl_wdata[strap_cfg_pkg::CTRL_RESET_BIT];

  // ****************************************
  // Strap capture
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn || sw_reset)
    begin
      captured_r <= 1'b0;
      strap_r    <= 3'h0;
    end
    else if (clk_en && !captured_r)
    begin
      captured_r <= 1'b1;
      strap_r    <= {autoneg_strap_enable, ability_strap_hi, ability_strap_lo};
    end
  end

  // Advertised set from ability straps
  always_comb
  begin
    case ({autoneg_strap_enable, ability_strap_hi, ability_strap_lo})
      3'h4:    strap_adv = strap_cfg_pkg::ADV_10_BOTH;
      3'h5:    strap_adv = strap_cfg_pkg::ADV_100_BOTH;
      3'h6:    strap_adv = strap_cfg_pkg::ADV_HALF_ONLY;
      3'h7:    strap_adv = strap_cfg_pkg::ADV_ALL;
      default: strap_adv = strap_cfg_pkg::ADV_ALL;
    endcase
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      autoneg_strap_enable_r      <= 1'b0;
      speed_r      <= 1'b0;
      duplex_r     <= 1'b0;
      iso_bit_r    <= 1'b0;
      soft_reset_r <= 1'b0;
      adv_r        <= strap_cfg_pkg::ADV_NONE;
    end
    else if (clk_en)
    begin
      soft_reset_r <= sw_reset;
      if (sw_reset)
        iso_bit_r <= 1'b0;
      if (!captured_r)
      begin
        autoneg_strap_enable_r  <= autoneg_strap_enable;
        speed_r  <= ability_strap_hi;
        duplex_r <= ability_strap_lo;
        adv_r    <= strap_adv;
      end
      else
      begin
        if (ctrl_wr && !sw_reset)
        begin
          autoneg_strap_enable_r   <= ctrl_wdata[strap_cfg_pkg::CTRL_AUTONEG_STRAP_ENABLE_BIT];
          speed_r   <= ctrl_wdata[strap_cfg_pkg::CTRL_SPEED_BIT];
          duplex_r  <= ctrl_wdata[strap_cfg_pkg::CTRL_DUPLEX_BIT];
          iso_bit_r <= ctrl_wdata[strap_cfg_pkg::CTRL_ISO_BIT];
        end
        if (adv_wr)
          adv_r <= adv_wdata;
      end
    end
  end

  // ****************************************
  // Negotiation and restart
  // ****************************************
  ability_resolver u_resolver
  (
    .local_ability   (adv_r),
    .partner_ability (partner_ability),
    .common_found    (common_found),
    .best_mode       (neg_mode)
  );

  always_ff @(posedge core_clk)
  begin
    if (!resetn || sw_reset)
    begin
      complete_r <= 1'b0;
      restart_r  <= 1'b0;
      mode_r     <= strap_cfg_pkg::MODE_10_HALF;
    end
    else if (clk_en)
    begin
      restart_r <= 1'b0;
      if (ctrl_wr && ctrl_wdata[strap_cfg_pkg::CTRL_RESTART_BIT] && autoneg_strap_enable_r)
      begin
        restart_r  <= 1'b1;
        complete_r <= 1'b0;
      end
      else if (!autoneg_strap_enable_r)
      begin
        complete_r <= 1'b0;
        mode_r     <= strap_cfg_pkg::link_mode_t'({speed_r, duplex_r});
      end
      else if (!complete_r && partner_valid && common_found)
      begin
        complete_r <= 1'b1;
        mode_r     <= neg_mode;
      end
    end
  end

  // ****************************************
  // Isolate exit timing
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn || sw_reset)
    begin
      isolate_r <= 1'b1;
      iso_cnt_r <= ISO_CNT_W_L'(ISO_RESET_CYC);
    end
    else if (clk_en)
    begin
      if (iso_bit_r)
      begin
        isolate_r <= 1'b1;
        iso_cnt_r <= ISO_CNT_W_L'(ISO_CLEAR_CYC);
      end
      else if (iso_cnt_r <= 1)
      begin
        isolate_r <= 1'b0;
        iso_cnt_r <= '0;
      end
      else
        iso_cnt_r <= iso_cnt_r - 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    basic_control_reg = 16'h0000;
    basic_control_reg[strap_cfg_pkg::CTRL_RESET_BIT]  = soft_reset_r;
    basic_control_reg[strap_cfg_pkg::CTRL_SPEED_BIT]  = speed_r;
    basic_control_reg[strap_cfg_pkg::CTRL_AUTONEG_STRAP_ENABLE_BIT]  = autoneg_strap_enable_r;
    basic_control_reg[strap_cfg_pkg::CTRL_ISO_BIT]    = iso_bit_r;
    basic_control_reg[strap_cfg_pkg::CTRL_DUPLEX_BIT] = duplex_r;
    advertised_ability_reg = 16'h0000;
    advertised_ability_reg[strap_cfg_pkg::ADV_MSB:strap_cfg_pkg::ADV_LSB] = adv_r;
    advertised_ability_reg[4:0] = strap_cfg_pkg::ADV_SELECTOR;
  end

  assign autoneg_active   = autoneg_strap_enable_r;
  assign autoneg_complete = complete_r;
  assign restart_pulse    = restart_r;
  assign isolate          = isolate_r;
  assign link_mode        = mode_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_forced_mode;
    @(posedge core_clk) disable iff (!resetn)
    clk_en && captured_r && !autoneg_strap_enable_r && !ctrl_wr
      |=> mode_r == strap_cfg_pkg::link_mode_t'({$past(speed_r), $past(duplex_r)});
  endproperty
  a_forced_mode: assert property (p_forced_mode) else $error("forced mode mismatch");

  property p_strap_hold;
    @(posedge core_clk) disable iff (!resetn)
    captured_r && !sw_reset |=> strap_r == $past(strap_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap capture changed");

  property p_adv_all;
    @(posedge core_clk) disable iff (!resetn)
    clk_en && !captured_r && !sw_reset && (strap_adv == strap_cfg_pkg::ADV_ALL)
      |=> adv_r == strap_cfg_pkg::ADV_ALL;
  endproperty
  a_adv_all: assert property (p_adv_all) else $error("advert not from straps");

  property p_restart;
    @(posedge core_clk) disable iff (!resetn)
    clk_en && ctrl_wr && !sw_reset && autoneg_strap_enable_r && ctrl_wdata[strap_cfg_pkg::CTRL_RESTART_BIT]
      |=> restart_r && !complete_r;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_best;
    @(posedge core_clk) disable iff (!resetn)
    $rose(complete_r) && $past(adv_r[3]) && $past(partner_ability[3])
      |-> mode_r == strap_cfg_pkg::MODE_100_FULL;
  endproperty
  a_best: assert property (p_best) else $error("not highest mode");

  property p_iso_clear;
    @(posedge core_clk) disable iff (!resetn)
    $fell(iso_bit_r) && iso_cnt_r == ISO_CNT_W_L'(ISO_CLEAR_CYC) |-> isolate_r;
  endproperty
  a_iso_clear: assert property (p_iso_clear) else $error("isolate left early");

  property p_iso_cnt_bound;
    @(posedge core_clk) disable iff (!resetn)
    iso_cnt_r <= ISO_CNT_W_L'(ISO_RESET_CYC);
  endproperty
  a_iso_cnt_bound: assert property (p_iso_cnt_bound) else $error("iso count too big");

  property p_ctrl_write;
    @(posedge core_clk) disable iff (!resetn)
    clk_en && captured_r && ctrl_wr && !sw_reset
      |=> autoneg_strap_enable_r == $past(ctrl_wdata[strap_cfg_pkg::CTRL_AUTONEG_STRAP_ENABLE_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

endmodule

`default_nettype wire

// ### verification/link_partner_model.sv
// Remote link partner: offers one ability set after a short or long delay.
// Assumes bench controls change just after core_clk rises.
`timescale 1ns/1ps
`default_nettype none

module link_partner_model
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] ability_cfg,
  input  wire logic       present,
  input  wire logic       slow,
  output logic [3:0]      partner_ability,
  output logic            partner_valid
);
  logic [3:0] wait_r;
  logic [3:0] last_r;

  always_ff @(posedge core_clk)
  begin
    if (!resetn || !present)
    begin
      wait_r        <= 4'h0;
      partner_valid <= 1'b0;
    end
    else if (wait_r == (slow ? 4'hC : 4'h1))
      partner_valid <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      last_r <= 4'h0;
    else if (partner_valid)
      last_r <= ability_cfg;
  end

  // Released lines show no stale abilities
  assign partner_ability = partner_valid ? ability_cfg : ~last_r;
endmodule

`default_nettype wire

// ### verification/autoneg_mode_strap_config_bench.sv
// Self-checking bench for the strap configuration block.
// Assumes the design package is compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module autoneg_mode_strap_config_bench;
  localparam int ISO_R = 20;
  localparam int ISO_C = 8;
  typedef struct packed {
    logic an; logic hi; logic lo; logic [3:0] adv; logic [1:0] mode;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{1'b0, 1'b0, 1'b0, 4'hF, 2'h0}, '{1'b0, 1'b0, 1'b1, 4'hF, 2'h1},
    '{1'b0, 1'b1, 1'b0, 4'hF, 2'h2}, '{1'b0, 1'b1, 1'b1, 4'hF, 2'h3},
    '{1'b1, 1'b0, 1'b0, 4'h3, 2'h0}, '{1'b1, 1'b0, 1'b1, 4'hC, 2'h0},
    '{1'b1, 1'b1, 1'b0, 4'h5, 2'h0}, '{1'b1, 1'b1, 1'b1, 4'hF, 2'h0}};
  localparam logic [3:0] PAB [5] = '{4'hF, 4'h6, 4'h3, 4'h1, 4'h2};
  localparam logic [1:0] PMODE [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};

  logic core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, ctrl_wr = 1'b0, adv_wr = 1'b0;
  logic an_s = 1'b0, hi_s = 1'b0, lo_s = 1'b0, present = 1'b0, slow = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000;
  logic [3:0]  adv_wdata = 4'h0, pab = 4'h0;
  wire logic [3:0]  partner_ability;
  wire logic        partner_valid, autoneg_active, autoneg_complete, restart_pulse, isolate;
  wire logic [15:0] basic_control_reg, advertised_ability_reg;
  strap_cfg_pkg::link_mode_t link_mode;
  int err_total = 0, n_checks = 0, cyc = 0;

  always #12.5 core_clk = ~core_clk;

  autoneg_mode_strap_config #(.ISO_RESET_CYC(ISO_R), .ISO_CLEAR_CYC(ISO_C))
    autoneg_mode_strap_config_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .autoneg_strap_enable(an_s), .ability_strap_hi(hi_s), .ability_strap_lo(lo_s),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .adv_wr(adv_wr), .adv_wdata(adv_wdata),
    .partner_ability(partner_ability), .partner_valid(partner_valid),
    .basic_control_reg(basic_control_reg), .advertised_ability_reg(advertised_ability_reg),
    .autoneg_active(autoneg_active), .autoneg_complete(autoneg_complete),
    .restart_pulse(restart_pulse), .isolate(isolate), .link_mode(link_mode));

  link_partner_model link_partner_model_inst (.core_clk(core_clk), .resetn(resetn),
    .ability_cfg(pab), .present(present), .slow(slow),
    .partner_ability(partner_ability), .partner_valid(partner_valid));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input strap_cfg_pkg::link_mode_t got, input logic [1:0] exp);
    n_checks++;
    if (got !== strap_cfg_pkg::link_mode_t'(exp))
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset(input logic an, input logic hi, input logic lo);
    @(posedge core_clk);
    resetn <= 1'b0;
    an_s <= an;
    hi_s <= hi;
    lo_s <= lo;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    step();
  endtask

  task automatic ctrl_write(input logic [15:0] d);
    @(posedge core_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge core_clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask

  task automatic wait_iso(output int n);
    n = 0;
    while (isolate !== 1'b0 && n < 40)
    begin
      step();
      n++;
    end
  endtask

  task automatic negotiate(input logic [3:0] ab, input logic sl, input logic [1:0] exp);
    int n;
    @(posedge core_clk);
    present <= 1'b0;
    pab <= ab;
    slow <= sl;
    @(posedge core_clk);
    ctrl_write(16'h1200);
    chk_val({14'h0, restart_pulse, autoneg_complete}, 16'h0002);
    @(posedge core_clk);
    present <= 1'b1;
    n = 0;
    while (autoneg_complete !== 1'b1 && n < 40)
    begin
      step();
      n++;
    end
    chk_val({15'h0, autoneg_complete}, 16'h0001);
    chk_mode(link_mode, exp);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      tally_and_finish;
    end
  end

  initial
  begin
    int n;
    foreach (ROWS[i])
    begin
      do_reset(ROWS[i].an, ROWS[i].hi, ROWS[i].lo);
      chk_val(advertised_ability_reg, {7'h00, ROWS[i].adv, 5'h01});
      chk_val({15'h0, autoneg_active}, {15'h0, ROWS[i].an});
      if (!ROWS[i].an)
        chk_mode(link_mode, ROWS[i].mode);
      @(posedge core_clk);
      {an_s, hi_s, lo_s} <= ~{ROWS[i].an, ROWS[i].hi, ROWS[i].lo};
      wait_iso(n);
      chk_val(16'(n > 0 && n + 4 <= ISO_R), 16'h0001);
      chk_val(advertised_ability_reg, {7'h00, ROWS[i].adv, 5'h01});
    end
    do_reset(1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 5; k++)
      negotiate(PAB[k], k[0], PMODE[k]);
    @(posedge core_clk);
    adv_wr <= 1'b1;
    adv_wdata <= 4'h5;
    @(posedge core_clk);
    adv_wr <= 1'b0;
    step();
    chk_val(advertised_ability_reg, 16'h00A1);
    negotiate(4'hF, 1'b1, 2'h2);
    @(posedge core_clk);
    present <= 1'b0;
    ctrl_write(16'h2100);
    step();
    chk_mode(link_mode, 2'h3);
    chk_val(basic_control_reg, 16'h2100);
    chk_val({15'h0, autoneg_active}, 16'h0000);
    ctrl_write(16'h0200);
    chk_val({15'h0, restart_pulse}, 16'h0000);
    ctrl_write(16'h0000);
    step();
    chk_mode(link_mode, 2'h0);
    ctrl_write(16'h3100);
    step();
    chk_val({15'h0, link_mode == strap_cfg_pkg::MODE_100_FULL}, 16'h0000);
    @(posedge core_clk);
    clk_en <= 1'b0;
    ctrl_write(16'h2100);
    chk_val({15'h0, autoneg_active}, 16'h0001);
    @(posedge core_clk);
    clk_en <= 1'b1;
    ctrl_write(16'h0400);
    step();
    chk_val({15'h0, isolate}, 16'h0001);
    ctrl_write(16'h0000);
    wait_iso(n);
    chk_val(16'(n > 0 && n <= ISO_C), 16'h0001);
    @(posedge core_clk);
    {an_s, hi_s, lo_s} <= 3'b010;
    ctrl_write(16'h8000);
    chk_val(basic_control_reg, 16'h8000);
    chk_val({15'h0, isolate}, 16'h0001);
    repeat (3) step();
    chk_mode(link_mode, 2'h2);
    chk_val(advertised_ability_reg, 16'h01E1);
    chk_val(basic_control_reg, 16'h2000);
    wait_iso(n);
    chk_val(16'(n > 0 && n + 3 <= ISO_R), 16'h0001);
    tally_and_finish;
  end
endmodule

`default_nettype wire
